// [i2cs_pkg.sv]
// Constants for the two-wire bus slave: register map, fields, states
package i2cs_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] I2CS_CTL_OFF  = 8'h00;
  localparam logic [7:0] I2CS_STAT_OFF = 8'h04;
  localparam logic [7:0] I2CS_ADDR_OFF = 8'h08;
  localparam logic [7:0] I2CS_RCV_OFF  = 8'h0C;
  localparam logic [7:0] I2CS_TRN_OFF  = 8'h10;

  // Control register fields
  localparam int I2CS_CTL_ON     = 15;
  localparam int I2CS_CTL_REL    = 12;
  localparam int I2CS_CTL_A10    = 10;
  localparam int I2CS_CTL_RECEIVE_STRETCH_ENABLE  = 6;

  // Status register fields
  localparam int I2CS_ST_TEN     = 8;
  localparam int I2CS_ST_OV      = 6;
  localparam int I2CS_ST_DIR     = 2;
  localparam int I2CS_ST_RBF     = 1;
  localparam int I2CS_ST_TBF     = 0;

  // Reset values
  localparam logic [9:0]  I2CS_ADDR_RST = 10'h000;
  localparam logic [15:0] I2CS_DATA_RST = 16'h0000;

  // Fixed first-byte prefix of a ten-bit address
  localparam logic [4:0] I2CS_TEN_PREFIX = 5'h1E;

  // Bit counts of a byte on the bus
  localparam logic [3:0] I2CS_BITS_RX = 4'h8;
  localparam logic [3:0] I2CS_BITS_TX = 4'h7;

  // Slave sequence states, one-hot
  typedef enum logic [6:0] {
    I2CS_IDLE  = 7'h01,
    I2CS_ADDR  = 7'h02,
    I2CS_ADDR2 = 7'h04,
    I2CS_RX    = 7'h08,
    I2CS_ACK   = 7'h10,
    I2CS_TX    = 7'h20,
    I2CS_TXACK = 7'h40
  } i2cs_state_e;

endpackage

// [i2cs_slave.sv]
// Two-wire bus slave with 7/10-bit address match and clock stretching
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module i2cs_slave
  import i2cs_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Bus clock line
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  // Bus data line
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Slave event pulse
  output logic             slave_event
);

  // Byte compare helper
  function automatic logic byte_eq(input logic [7:0] a, input logic [7:0] b);
    byte_eq = (a == b);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        scl_m_q, scl_s_q, scl_p_q;
  logic        sda_m_q, sda_s_q, sda_p_q;
  logic        scl_rise, scl_fall, start_det, stop_det;
  i2cs_state_e st_q, nxt_q, dec_nxt;
  logic [3:0]  cnt_q;
  logic [7:0]  rsr_q, txsh_q, rcv_q, trn_q;
  logic [9:0]  sadr_q;
  logic        on_q, rel_q, a10_q, receive_stretch_enable_q;
  logic        rbf_q, tbf_q, ov_q, ten_q, dir_q;
  logic        ack_q, evt_q, nack_q, loaded_q, hold_q;
  logic        byte_done, ninth_fall, txack_fall, tx_enter, tx_load, auto_clr;
  logic        dec_ack, dec_evt, dec_load, dec_ov, dec_set_ten, dec_clr_ten;
  logic        dec_dir, m_first;
  logic        wr_ctl, wr_stat, wr_addr, wr_trn, rd_rcv;
  logic [15:0] rd_mux, rdata_q;
  logic        evt_out_q;

  //////////////////////////////////////////////////////////////////////////
  // Line synchronisers and edge finders
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Bus events seen from the settled copies
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = on_q & scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = on_q & scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  //////////////////////////////////////////////////////////////////////////
  // Register port decode
  assign wr_ctl  = reg_wr & (reg_addr == I2CS_CTL_OFF);
  assign wr_stat = reg_wr & (reg_addr == I2CS_STAT_OFF);
  assign wr_addr = reg_wr & (reg_addr == I2CS_ADDR_OFF);
  assign wr_trn  = reg_wr & (reg_addr == I2CS_TRN_OFF);
  assign rd_rcv  = reg_rd & (reg_addr == I2CS_RCV_OFF);

  //////////////////////////////////////////////////////////////////////////
  // Byte-end decision
  assign byte_done  = scl_fall & (cnt_q == I2CS_BITS_RX)
                      & ((st_q == I2CS_ADDR) | (st_q == I2CS_ADDR2) | (st_q == I2CS_RX));
  assign ninth_fall = scl_fall & (st_q == I2CS_ACK);
  assign txack_fall = scl_fall & (st_q == I2CS_TXACK);
  assign m_first    = (rsr_q[7:3] == I2CS_TEN_PREFIX) & (rsr_q[2:1] == sadr_q[9:8]);

  always_comb begin
    dec_nxt     = I2CS_IDLE;
    dec_ack     = 1'b0;
    dec_evt     = 1'b0;
    dec_load    = 1'b0;
    dec_ov      = 1'b0;
    dec_set_ten = 1'b0;
    dec_clr_ten = 1'b0;
    dec_dir     = rsr_q[0];
    case (st_q)
      I2CS_ADDR: begin
        if (a10_q) begin
          if (m_first && !rsr_q[0]) begin
            dec_ack     = 1'b1;
            dec_evt     = 1'b1;
            dec_clr_ten = 1'b1;
            dec_nxt     = I2CS_ADDR2;
          end else if (m_first && ten_q) begin
            dec_ack = 1'b1;
            dec_evt = 1'b1;
            dec_nxt = I2CS_TX;
          end else begin
            dec_clr_ten = 1'b1;
          end
        end else if (rsr_q[7:1] == sadr_q[6:0]) begin
          dec_ack = 1'b1;
          dec_evt = 1'b1;
          dec_nxt = rsr_q[0] ? I2CS_TX : I2CS_RX;
        end
      end
      I2CS_ADDR2: begin
        dec_dir = 1'b0;
        if (byte_eq(rsr_q, sadr_q[7:0])) begin
          dec_ack     = 1'b1;
          dec_evt     = 1'b1;
          dec_set_ten = 1'b1;
          dec_nxt     = I2CS_RX;
        end else begin
          dec_clr_ten = 1'b1;
        end
      end
      I2CS_RX: begin
        dec_dir  = 1'b0;
        dec_load = ~rbf_q;
        dec_ack  = ~rbf_q & ~ov_q;
        dec_ov   = rbf_q;
        dec_evt  = 1'b1;
        dec_nxt  = I2CS_RX;
      end
      default: begin
        dec_nxt = I2CS_IDLE;
      end
    endcase
  end

  // Transmit entry, shift load and automatic release clear
  assign tx_enter = (ninth_fall & (nxt_q == I2CS_TX)) | (txack_fall & ~nack_q);
  assign tx_load  = tx_enter ? tbf_q : ((st_q == I2CS_TX) & ~loaded_q & tbf_q);
  assign auto_clr = (tx_enter & ~tbf_q)
                    | (ninth_fall & (nxt_q == I2CS_RX) & receive_stretch_enable_q & rbf_q);

  //////////////////////////////////////////////////////////////////////////
  // Slave sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q     <= I2CS_IDLE;
      nxt_q    <= I2CS_IDLE;
      cnt_q    <= 4'h0;
      rsr_q    <= 8'h00;
      ack_q    <= 1'b0;
      evt_q    <= 1'b0;
      nack_q   <= 1'b0;
      dir_q    <= 1'b0;
    end else if (!on_q || stop_det) begin
      st_q  <= I2CS_IDLE;
      ack_q <= 1'b0;
    end else if (start_det) begin
      st_q  <= I2CS_ADDR;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      case (st_q)
        I2CS_ADDR, I2CS_ADDR2, I2CS_RX: begin
          if (scl_rise) begin
            rsr_q <= {rsr_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            ack_q <= dec_ack;
            evt_q <= dec_evt;
            nxt_q <= dec_nxt;
            dir_q <= dec_dir;
            st_q  <= (dec_nxt == I2CS_IDLE) ? I2CS_IDLE : I2CS_ACK;
          end
        end
        I2CS_ACK: begin
          if (ninth_fall) begin
            ack_q <= 1'b0;
            st_q  <= nxt_q;
            cnt_q <= 4'h0;
          end
        end
        I2CS_TX: begin
          if (scl_fall && loaded_q) begin
            if (cnt_q == I2CS_BITS_TX) begin
              st_q  <= I2CS_TXACK;
              cnt_q <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        I2CS_TXACK: begin
          if (scl_rise) begin
            nack_q <= sda_s_q;
          end else if (txack_fall) begin
            st_q  <= nack_q ? I2CS_IDLE : I2CS_TX;
            cnt_q <= 4'h0;
          end
        end
        default: begin
          st_q <= I2CS_IDLE;
        end
      endcase
    end
  end

  // Transmit shifter, loaded from the single transmit register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txsh_q   <= 8'h00;
      loaded_q <= 1'b0;
    end else if (tx_load) begin
      txsh_q   <= trn_q;
      loaded_q <= 1'b1;
    end else if (tx_enter || st_q != I2CS_TX) begin
      loaded_q <= 1'b0;
    end else if (scl_fall && loaded_q) begin
      txsh_q <= {txsh_q[6:0], 1'b1};
    end
  end

  // Event pulse, one cycle after the ninth falling edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_out_q <= 1'b0;
    end else begin
      evt_out_q <= (ninth_fall & evt_q) | txack_fall;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control and address registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      on_q    <= 1'b0;
      a10_q   <= 1'b0;
      receive_stretch_enable_q <= 1'b0;
      sadr_q  <= I2CS_ADDR_RST;
    end else begin
      if (wr_ctl) begin
        on_q    <= reg_wdata[I2CS_CTL_ON];
        a10_q   <= reg_wdata[I2CS_CTL_A10];
        receive_stretch_enable_q <= reg_wdata[I2CS_CTL_RECEIVE_STRETCH_ENABLE];
      end
      if (wr_addr) begin
        sadr_q <= reg_wdata[9:0];
      end
    end
  end

  // Clock release bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rel_q <= 1'b1;
    end else if (wr_ctl && reg_wdata[I2CS_CTL_REL]) begin
      rel_q <= 1'b1;
    end else if (auto_clr) begin
      rel_q <= 1'b0;
    end else if (wr_ctl && receive_stretch_enable_q) begin
      rel_q <= 1'b0;
    end
  end

  // Clock hold: only after the line is seen low with release clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_q <= 1'b0;
    end else if (rel_q || !on_q) begin
      hold_q <= 1'b0;
    end else if (!scl_s_q) begin
      hold_q <= 1'b1;
    end
  end

  // Buffer flags; hardware set wins over software clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rcv_q <= 8'h00;
      trn_q <= 8'h00;
      rbf_q <= 1'b0;
      tbf_q <= 1'b0;
      ov_q  <= 1'b0;
      ten_q <= 1'b0;
    end else begin
      if (byte_done && dec_load) begin
        rcv_q <= rsr_q;
        rbf_q <= 1'b1;
      end else if (rd_rcv) begin
        rbf_q <= 1'b0;
      end
      if (byte_done && dec_ov) begin
        ov_q <= 1'b1;
      end else if (wr_stat) begin
        ov_q <= reg_wdata[I2CS_ST_OV];
      end
      if (wr_trn) begin
        trn_q <= reg_wdata[7:0];
        tbf_q <= 1'b1;
      end else if (tx_load) begin
        tbf_q <= 1'b0;
      end
      if (byte_done && dec_set_ten) begin
        ten_q <= 1'b1;
      end else if (byte_done && dec_clr_ten) begin
        ten_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux and registered read data
  always_comb begin
    rd_mux = I2CS_DATA_RST;
    case (reg_addr)
      I2CS_CTL_OFF: begin
        rd_mux[I2CS_CTL_ON]    = on_q;
        rd_mux[I2CS_CTL_REL]   = rel_q;
        rd_mux[I2CS_CTL_A10]   = a10_q;
        rd_mux[I2CS_CTL_RECEIVE_STRETCH_ENABLE] = receive_stretch_enable_q;
      end
      I2CS_STAT_OFF: begin
        rd_mux[I2CS_ST_TEN] = ten_q;
        rd_mux[I2CS_ST_OV]  = ov_q;
        rd_mux[I2CS_ST_DIR] = dir_q;
        rd_mux[I2CS_ST_RBF] = rbf_q;
        rd_mux[I2CS_ST_TBF] = tbf_q;
      end
      I2CS_ADDR_OFF: rd_mux = {6'h00, sadr_q};
      I2CS_RCV_OFF:  rd_mux = {8'h00, rcv_q};
      I2CS_TRN_OFF:  rd_mux = {8'h00, trn_q};
      default:       rd_mux = I2CS_DATA_RST;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= I2CS_DATA_RST;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= I2CS_DATA_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive, open drain
  assign reg_rdata   = rdata_q;
  assign scl_o       = 1'b0;
  assign scl_oe      = hold_q;
  assign sda_o       = 1'b0;
  assign sda_oe      = ack_q | ((st_q == I2CS_TX) & loaded_q & ~txsh_q[7]);
  assign slave_event = evt_out_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  idle_start_a: assert property (@(posedge clock) disable iff (rst)
    (st_q == I2CS_IDLE) && !start_det |=> (st_q == I2CS_IDLE))
    else $error("left idle without a start");

  addr_ack_a: assert property (@(posedge clock) disable iff (rst)
    byte_done && (st_q == I2CS_ADDR) && !a10_q && (rsr_q[7:1] == sadr_q[6:0])
    |=> ack_q && sda_oe)
    else $error("matched address not acknowledged");

  event_ninth_a: assert property (@(posedge clock) disable iff (rst)
    ninth_fall && evt_q |=> slave_event ##1 !slave_event)
    else $error("event pulse missing after ninth fall");

  rx_load_a: assert property (@(posedge clock) disable iff (rst)
    byte_done && (st_q == I2CS_RX) && !rbf_q && !ov_q
    |=> rbf_q && ack_q && (rcv_q == $past(rsr_q)))
    else $error("received byte not moved to buffer");

  overflow_keep_a: assert property (@(posedge clock) disable iff (rst)
    byte_done && (st_q == I2CS_RX) && rbf_q
    |=> !ack_q && ov_q && (rcv_q == $past(rcv_q)))
    else $error("overflow handling wrong");

  ov_nack_a: assert property (@(posedge clock) disable iff (rst)
    byte_done && (st_q == I2CS_RX) && ov_q && !rbf_q |=> !ack_q && rbf_q)
    else $error("overflow byte acknowledged or not loaded");

  tx_stretch_a: assert property (@(posedge clock) disable iff (rst)
    tx_enter && !tbf_q && !wr_ctl |=> !rel_q)
    else $error("transmit stretch missing");

  tx_nostretch_a: assert property (@(posedge clock) disable iff (rst)
    tx_enter && tbf_q && rel_q |=> rel_q)
    else $error("stretched although transmit loaded");

  rel_ignore_a: assert property (@(posedge clock) disable iff (rst)
    wr_ctl && !receive_stretch_enable_q && !reg_wdata[I2CS_CTL_REL] && !auto_clr
    |=> rel_q == $past(rel_q))
    else $error("release write not ignored");

  hold_low_a: assert property (@(posedge clock) disable iff (rst)
    $rose(scl_oe) |-> $past(!scl_s_q) && $past(!rel_q))
    else $error("clock driven low before line seen low");

  release_a: assert property (@(posedge clock) disable iff (rst)
    rel_q |=> !scl_oe)
    else $error("clock held while released");

endmodule

// [i2cs_bus_master.sv]
// Behavioural bus master driving the two-wire link for the bench
`timescale 1ns/1ns
module i2cs_bus_master (
  // Bench clock, only used to keep line changes off its rising edge
  input  wire logic clock,
  // Open-drain pulls, high drives the line low
  output logic      scl_low,
  output logic      sda_low,
  // Wired line levels
  input  wire logic scl,
  input  wire logic sda,
  // Clock waits that ran out
  output int        stuck
);
  // Both lines released at time zero
  initial begin
    scl_low = 0;
    sda_low = 0;
    stuck = 0;
  end
  ////////////////////////////////////////
  // Let the clock rise, waiting while the slave holds it
  task automatic rise();
    int n;
    scl_low = 0;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #50;
      n++;
    end
    if (n == 4000)
      stuck++;
  endtask
  // One bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic v, output logic s);
    #100 sda_low = !v;
    #100 rise();
    #100 s = sda;
    #100 scl_low = 1;
  endtask
  // Start or repeated start
  task automatic start();
    @(negedge clock);
    sda_low = 0;
    #100 rise();
    #100 sda_low = 1;
    #100 scl_low = 1;
  endtask
  // Stop, then bus free
  task automatic stop();
    @(negedge clock);
    sda_low = 1;
    #100 rise();
    #100 sda_low = 0;
    #200;
  endtask
  // Byte out, MSB first, then the slave's acknowledge
  task automatic wr_byte(input logic [7:0] v, output logic a);
    logic s;
    @(negedge clock);
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], s);
    bit_io(1'b1, a);
  endtask
  // Byte in, then our acknowledge (0) or not (1)
  task automatic rd_byte(input logic a, output logic [7:0] v);
    logic s;
    @(negedge clock);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(a, s);
  endtask
endmodule

// [i2cs_slave_test.sv]
// Self-checking bench for the two-wire bus slave against a behavioural model
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module i2cs_slave_test;
  import i2cs_pkg::*;
  logic        clock, rst, reg_wr, reg_rd, scl_o, scl_oe, sda_o, sda_oe, slave_event;
  logic        m_scl, m_sda, ack;
  logic [7:0]  reg_addr, b;
  logic [15:0] reg_wdata, reg_rdata, d, ctl;
  logic [31:0] seed;
  int          errors, checks_done, events, exp_ev, held, stuck, receive_full_flag, ov;
  int          rcv_q[$];
  // Open-drain lines with pull-ups: the slave drives its output level while enabled
  wire         scl_w = (scl_oe ? scl_o : 1'b1) & !m_scl;
  wire         sda_w = (sda_oe ? sda_o : 1'b1) & !m_sda;

  i2cs_slave uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .slave_event(slave_event));
  i2cs_bus_master m (.clock(clock), .scl_low(m_scl), .sda_low(m_sda), .scl(scl_w), .sda(sda_w),
    .stuck(stuck));

  // System clock, 50 ns
  initial begin
    clock = 0;
    forever #25 clock = !clock;
  end
  // Run limit: a hang counts as a mismatch and ends in the verdict
  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    test_done();
  end
  // Count event pulses and clock-hold cycles
  always @(posedge clock) begin
    if (slave_event === 1'b1)
      events++;
    if (scl_oe === 1'b1)
      held++;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge clock);
    reg_wr <= 0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clock);
    reg_rd <= 0;
    #1 d = reg_rdata;
    `CHK(d, e)
  endtask
  // Read the receive buffer against the model
  task automatic pop_rcv();
    int v;
    v = rcv_q.pop_front();
    receive_full_flag = 0;
    rd(I2CS_RCV_OFF, 16'(v));
  endtask
  // Send a data byte; model decides load and acknowledge
  task automatic send(input logic [7:0] v);
    logic e;
    e = (receive_full_flag != 0 || ov != 0);
    if (receive_full_flag != 0)
      ov = 1;
    else
      rcv_q.push_back(v);
    receive_full_flag = 1;
    exp_ev++;
    m.wr_byte(v, ack);
    `CHK(ack, e)
  endtask
  // Wait for the clock hold, service a register, then release
  task automatic serve(input logic [7:0] a, input logic [15:0] v);
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 800) begin
      @(posedge clock);
      n++;
    end
    if (n == 800) begin
      errors++;
      test_done();
    end
    repeat (20) @(posedge clock);
    `CHK(scl_oe, 1'b1)
    if (a == I2CS_RCV_OFF)
      pop_rcv();
    else
      wr(a, v);
    wr(I2CS_CTL_OFF, ctl);
    repeat (4) @(posedge clock);
    `CHK(scl_oe, 1'b0)
  endtask
  // End of a test: event count against the model
  task automatic note(input string s);
    `CHK(events, exp_ev)
    `CHK(stuck, 0)
    $display("test %s ends, errors %0d", s, errors);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1;
    reg_addr = 0;
    reg_wdata = 0;
    reg_wr = 0;
    reg_rd = 0;
    seed = 32'hb4cc;
    repeat (3) @(posedge clock);
    rst <= 0;
    // Reset values, unmapped place, address register
    rd(I2CS_CTL_OFF, 16'h1000);
    rd(I2CS_STAT_OFF, 16'h0000);
    rd(8'h14, 16'h0000);
    wr(I2CS_ADDR_OFF, 16'h0055);
    rd(I2CS_ADDR_OFF, 16'h0055);
    wr(I2CS_CTL_OFF, 16'h8000);
    rd(I2CS_CTL_OFF, 16'h9000);
    m.wr_byte(8'hAA, ack);
    `CHK(ack, 1'b1)
    m.stop();
    note("idle");
    // Seven-bit receive with stretching
    ctl = 16'h9040;
    wr(I2CS_CTL_OFF, ctl);
    m.start();
    exp_ev++;
    m.wr_byte(8'hAA, ack);
    `CHK(ack, 1'b0)
    rd(I2CS_STAT_OFF, 16'h0000);
    seed = xs(seed);
    fork
      begin
        send(seed[7:0]);
        m.stop();
      end
      serve(I2CS_RCV_OFF, 16'h0000);
    join
    // Buffer read between acknowledge and ninth fall: no stretch
    m.start();
    exp_ev++;
    m.wr_byte(8'hAA, ack);
    `CHK(ack, 1'b0)
    held = 0;
    seed = xs(seed);
    fork
      send(seed[7:0]);
      begin
        repeat (10) @(posedge clock);
        for (int n = 0; n < 400 && sda_oe !== 1'b1; n++)
          @(posedge clock);
        pop_rcv();
      end
    join
    m.stop();
    `CHK(held, 0)
    m.start();
    m.wr_byte(8'hAC, ack);
    `CHK(ack, 1'b1)
    m.stop();
    note("receive");
    // Overflow, then load with overflow still set
    ctl = 16'h9000;
    wr(I2CS_CTL_OFF, ctl);
    held = 0;
    m.start();
    exp_ev++;
    m.wr_byte(8'hAA, ack);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      send(seed[7:0]);
    end
    rd(I2CS_STAT_OFF, 16'h0042);
    pop_rcv();
    seed = xs(seed);
    send(seed[7:0]);
    m.stop();
    `CHK(held, 0)
    pop_rcv();
    wr(I2CS_STAT_OFF, 16'h0000);
    ov = 0;
    rd(I2CS_STAT_OFF, 16'h0000);
    note("overflow");
    // Seven-bit transmit, second byte loaded early
    m.start();
    exp_ev += 3;
    m.wr_byte(8'hAB, ack);
    `CHK(ack, 1'b0)
    seed = xs(seed);
    fork
      m.rd_byte(1'b0, b);
      begin
        serve(I2CS_TRN_OFF, {8'h00, seed[7:0]});
        repeat (40) @(posedge clock);
        wr(I2CS_TRN_OFF, {8'h00, seed[15:8]});
      end
    join
    `CHK(b, seed[7:0])
    held = 0;
    m.rd_byte(1'b1, b);
    `CHK(b, seed[15:8])
    rd(I2CS_STAT_OFF, 16'h0004);
    m.stop();
    `CHK(held, 0)
    note("transmit");
    // Ten-bit mismatch, match, receive, repeated start and transmit
    wr(I2CS_ADDR_OFF, 16'h02B5);
    ctl = 16'h9400;
    wr(I2CS_CTL_OFF, ctl);
    m.start();
    m.wr_byte(8'hF6, ack);
    `CHK(ack, 1'b1)
    m.stop();
    m.start();
    exp_ev += 2;
    m.wr_byte(8'hF4, ack);
    `CHK(ack, 1'b0)
    m.wr_byte(8'hB5, ack);
    `CHK(ack, 1'b0)
    rd(I2CS_STAT_OFF, 16'h0100);
    seed = xs(seed);
    send(seed[7:0]);
    pop_rcv();
    m.start();
    exp_ev += 3;
    m.wr_byte(8'hF5, ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      fork
        m.rd_byte(1'(i), b);
        serve(I2CS_TRN_OFF, {8'h00, seed[7:0]});
      join
      `CHK(b, seed[7:0])
    end
    m.stop();
    note("ten bit");
    // Reset in mid-run brings back the reset values
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    rd(I2CS_CTL_OFF, 16'h1000);
    rd(I2CS_STAT_OFF, 16'h0000);
    rd(I2CS_ADDR_OFF, {6'h00, I2CS_ADDR_RST});
    test_done();
  end
endmodule
